// ### bench/cip_core_model.sv
// cpu core and external pin side of the priority controller
module cip_core_model (
    input wire logic mclk,
    output logic [2:0] ext_irq,
    output logic core_lvl_wr,
    output logic [3:0] core_lvl_val,
    output logic instr_disable_active,
    output logic [3:0] user_irq_level,
    output logic user_irq_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle pins, one user request held at top priority
    initial begin
        {ext_irq, core_lvl_wr, core_lvl_val, instr_disable_active} = '0;
        user_irq_level = 4'hf;
        user_irq_req = 1'b1;
    end
    // core forces a new level for one cycle
    task automatic load(input logic [3:0] v);
        @(posedge mclk);
        core_lvl_wr <= 1'b1;
        core_lvl_val <= v;
        @(posedge mclk);
        core_lvl_wr <= 1'b0;
    endtask
    // pin levels and the disable-instruction flag
    task automatic pins(input logic [2:0] e, input logic d);
        @(posedge mclk);
        ext_irq <= e;
        instr_disable_active <= d;
    endtask
endmodule

// ### bench/cpu_interrupt_priority_ctrl_tb.sv
module cpu_interrupt_priority_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hf, user_irq_level, core_lvl_val, cpu_level;
    logic [2:0] ext_irq, ext_irq_event, v;
    logic pready, pslverr, core_lvl_wr, instr_disable_active, user_irq_req;
    logic user_irq_take, alt_vector_sel, irq;
    logic [32:0] exp_q[$];
    logic [15:0] lf = 16'd19627;
    int n_fail = 0, check_count = 0, cycles = 0, evt_n = 0;
    always #5 mclk = ~mclk;
    cip_ctrl u_cip_ctrl (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .ext_irq, .core_lvl_wr, .core_lvl_val, .instr_disable_active,
        .user_irq_level, .user_irq_req, .user_irq_take, .ext_irq_event, .alt_vector_sel, .cpu_level, .irq);
    cip_core_model u_cip_core_model (.mclk, .ext_irq, .core_lvl_wr, .core_lvl_val, .instr_disable_active,
        .user_irq_level, .user_irq_req);
    // random source for register data
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, returns once its effects have landed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // read monitor: oldest note against error flag and data
    always @(posedge mclk) begin
        cycles++;
        if (nrst) evt_n += $countones(ext_irq_event);
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd(12'h00c, 33'h0);
        lf = lfsr_next(lf);
        v = lf[2:0];
        apb(1'b1, 12'h000, {24'h0, v, 5'h0});
        rd(12'h000, {25'h0, v, 5'h0});
        check(cpu_level, {1'b0, v});
        apb(1'b1, 12'h008, 32'h8000);
        apb(1'b1, 12'h000, {24'h0, ~v, 5'h0});
        rd(12'h000, {25'h0, v, 5'h0});
        apb(1'b1, 12'h008, 32'h0);
        $display("level tests done");
        u_cip_core_model.load(4'hc);
        rd(12'h004, 33'h8);
        rd(12'h000, 33'h80);
        check(user_irq_take, 1'b0);
        apb(1'b1, 12'h004, 32'h0);
        check(cpu_level, 4'h4);
        check(user_irq_take, 1'b1);
        apb(1'b1, 12'h004, 32'h8);
        rd(12'h004, 33'h0);
        u_cip_core_model.load(4'h7);
        repeat (2) @(posedge mclk);
        check(cpu_level, 4'h7);
        check(user_irq_take, 1'b0);
        $display("priority tests done");
        apb(1'b1, 12'h00c, 32'h8007);
        u_cip_core_model.pins(3'h7, 1'b1);
        rd(12'h010, 33'h0);
        u_cip_core_model.pins(3'h0, 1'b1);
        rd(12'h00c, 33'hc007);
        check(alt_vector_sel, 1'b1);
        rd(12'h010, 33'h7);
        check(irq, 1'b0);
        apb(1'b1, 12'h014, 32'h7);
        check(irq, 1'b1);
        apb(1'b1, 12'h010, 32'h7);
        check(irq, 1'b0);
        check(evt_n, 3);
        apb(1'b1, 12'h00c, 32'h0);
        check(alt_vector_sel, 1'b0);
        u_cip_core_model.pins(3'h7, 1'b0);
        rd(12'h010, 33'h7);
        check(evt_n, 6);
        rd(12'h018, 33'h100000000);
        $display("edge and bus tests done");
        finish_test();
    end
endmodule

// ### verilog/cip_ctrl.sv
`include "cip_params.svh"
// Behaviour
// - three-bit priority status field holds cpu level 0 to 7 in binary
// - fourth priority bit in core control joins status field as msb
// - user interrupts blocked whenever the fourth priority bit is set
// - nesting disable makes the three-bit status field ignore software writes
// - fourth bit reads one above level seven, bit 3, software may only clear
// - each external input edge polarity: one negative, zero positive, reset zero
module cip_ctrl (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] ext_irq,
    input wire logic core_lvl_wr,
    input wire logic [3:0] core_lvl_val,
    input wire logic instr_disable_active,
    input wire logic [3:0] user_irq_level,
    input wire logic user_irq_req,
    output logic user_irq_take,
    output logic [2:0] ext_irq_event,
    output logic alt_vector_sel,
    output logic [3:0] cpu_level,
    output logic irq
);
    // priority level state
    logic [2:0] prio_lo_ff;
    logic prio3_ff;
    // control register bits
    logic nest_dis_ff;
    logic alt_ff;
    logic idis_ff;
    logic [2:0] ep_ff;
    // external input history and sticky status
    logic [2:0] ext_q_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    // registered outputs
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic take_ff;
    logic [2:0] evt_ff;
    logic irq_ff;

    // edge test for one input: polarity one looks for a fall, zero for a rise
    function automatic logic edge_seen(input logic neg_sel, input logic prev, input logic now);
        return neg_sel ? (prev && !now) : (!prev && now);
    endfunction

    // apb phases: acc is the first access cycle, done the cycle pready stands high
    wire acc = psel && penable && !pready_ff;
    wire done = psel && penable && pready_ff;
    // writes land at the edge that samples pready high, never before
    wire wr = done && pwrite && pstrb[0];
    wire wr_hi = done && pwrite && pstrb[1];

    // register address decode
    wire hit_st = paddr == `CIP_OFS_STATUS;
    wire hit_co = paddr == `CIP_OFS_CORE;
    wire hit_c1 = paddr == `CIP_OFS_ICTL1;
    wire hit_c2 = paddr == `CIP_OFS_ICTL2;
    wire hit_is = paddr == `CIP_OFS_IRQ_STAT;
    wire hit_im = paddr == `CIP_OFS_IRQ_MASK;
    wire mapped = hit_st || hit_co || hit_c1 || hit_c2 || hit_is || hit_im;

    // current four-bit cpu priority level
    wire cip_pkg::cip_level_t lvl = {prio3_ff, prio_lo_ff};

    // edge detection per input with selectable polarity
    logic [2:0] edge_hit;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            assign edge_hit[g] = edge_seen(ep_ff[g], ext_q_ff[g], ext_irq[g]);
        end
    endgenerate

    // next status field: core update wins, sw write only when nesting allowed
    wire sw_prio_wr = wr && hit_st && !nest_dis_ff;
    wire [2:0] nxt_prio_lo = core_lvl_wr ? core_lvl_val[2:0]
                           : sw_prio_wr ? pwdata[`CIP_STATUS_PRIO_HI:`CIP_STATUS_PRIO_LO]
                           : prio_lo_ff;
    // fourth bit: core may set or clear, software may only clear
    wire sw_prio3_clr = wr && hit_co && !pwdata[`CIP_CORE_PRIO3];
    wire nxt_prio3 = core_lvl_wr ? core_lvl_val[3]
                   : sw_prio3_clr ? 1'b0 : prio3_ff;
    // sticky events, set beats write-one-clear
    wire [2:0] stat_clr = (wr && hit_is) ? pwdata[2:0] : 3'h0;
    wire [2:0] nxt_irq_stat = (irq_stat_ff & ~stat_clr) | edge_hit;
    // interrupt level follows the new status against the mask in force
    wire nxt_irq = |(nxt_irq_stat & irq_mask_ff);

    // read mux, unmapped offsets read zero
    wire [31:0] rd_mux = hit_st ? {24'h0, prio_lo_ff, 5'h0}
                       : hit_co ? {28'h0, prio3_ff, 3'h0}
                       : hit_c1 ? {16'h0, nest_dis_ff, 15'h0}
                       : hit_c2 ? {16'h0, alt_ff, idis_ff, 11'h0, ep_ff}
                       : hit_is ? {29'h0, irq_stat_ff}
                       : hit_im ? {29'h0, irq_mask_ff}
                       : 32'h0;

    // user request gated by level; level 7 and levels 8 to 15 block everything
    wire lvl_open = !prio3_ff && (lvl != `CIP_USER_OFF_LVL);
    wire nxt_take = user_irq_req && lvl_open && (user_irq_level > lvl);

    // low three priority bits
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prio_lo_ff <= `CIP_RST_PRIO;
        end else begin
            prio_lo_ff <= nxt_prio_lo;
        end
    end

    // fourth priority bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prio3_ff <= 1'b0;
        end else begin
            prio3_ff <= nxt_prio3;
        end
    end

    // nesting disable bit, upper byte lane
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nest_dis_ff <= 1'b0;
        end else if (wr_hi && hit_c1) begin
            nest_dis_ff <= pwdata[`CIP_ICTL1_NEST];
        end
    end

    // alternate vector select, upper byte lane
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            alt_ff <= 1'b0;
        end else if (wr_hi && hit_c2) begin
            alt_ff <= pwdata[`CIP_ICTL2_ALT];
        end
    end

    // edge polarity bits, low byte lane
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ep_ff <= `CIP_RST_EP;
        end else if (wr && hit_c2) begin
            ep_ff <= pwdata[`CIP_ICTL2_EP_HI:0];
        end
    end

    // interrupt mask
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_ff <= 3'h0;
        end else if (wr && hit_im) begin
            irq_mask_ff <= pwdata[2:0];
        end
    end

    // pin history and disable-instruction flag
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_q_ff <= 3'h0;
            idis_ff <= 1'b0;
        end else begin
            ext_q_ff <= ext_irq;
            idis_ff <= instr_disable_active;
        end
    end

    // sticky status, event pulses and interrupt level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_ff <= 3'h0;
            evt_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            evt_ff <= edge_hit;
            irq_ff <= nxt_irq;
        end
    end

    // accepted user request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            take_ff <= 1'b0;
        end else begin
            take_ff <= nxt_take;
        end
    end

    // apb answer, one wait state; read data stands until the next read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= acc;
            pslverr_ff <= acc && !mapped;
            if (acc && !pwrite) prdata_ff <= rd_mux;
        end
    end

    // outputs straight from their flip-flops
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign user_irq_take = take_ff;
    assign ext_irq_event = evt_ff;
    assign alt_vector_sel = alt_ff;
    assign cpu_level = lvl;
    assign irq = irq_ff;

    // status field frozen while nesting is disabled
    a_status_locked: assert property (@(posedge mclk) disable iff (!nrst)
        (nest_dis_ff && !core_lvl_wr) |=> $stable(prio_lo_ff))
        else $error("status field changed while nesting disabled");

    // status field takes a software write while nesting is allowed
    a_status_write: assert property (@(posedge mclk) disable iff (!nrst)
        (sw_prio_wr && !core_lvl_wr) |=> prio_lo_ff == $past(pwdata[`CIP_STATUS_PRIO_HI:`CIP_STATUS_PRIO_LO]))
        else $error("status field write lost");

    // software never sets the fourth bit
    a_bit3_no_set: assert property (@(posedge mclk) disable iff (!nrst)
        (!prio3_ff && !core_lvl_wr) |=> !prio3_ff)
        else $error("fourth priority bit set by software");

    // software clear of the fourth bit lands
    a_bit3_sw_clr: assert property (@(posedge mclk) disable iff (!nrst)
        (sw_prio3_clr && !core_lvl_wr) |=> !cpu_level[3])
        else $error("fourth priority bit not cleared");

    // levels 8 to 15 block user requests
    a_bit3_blocks: assert property (@(posedge mclk) disable iff (!nrst)
        prio3_ff |=> !user_irq_take)
        else $error("user interrupt taken at level above seven");

    // level 7 blocks user requests
    a_lvl7_blocks: assert property (@(posedge mclk) disable iff (!nrst)
        (cpu_level == 4'h7) |=> !user_irq_take)
        else $error("user interrupt taken at level seven");

    // a taken request had a higher level than the cpu
    a_take_cause: assert property (@(posedge mclk) disable iff (!nrst)
        user_irq_take |-> $past(user_irq_req && (user_irq_level > cpu_level)))
        else $error("user interrupt taken without higher level");

    // core load sets all four level bits
    a_level_join: assert property (@(posedge mclk) disable iff (!nrst)
        core_lvl_wr |=> cpu_level == $past(core_lvl_val))
        else $error("cpu level not formed from both fields");

    // rising edge on input 0 with positive polarity
    a_rise_evt0: assert property (@(posedge mclk) disable iff (!nrst)
        (!ep_ff[0] && !$past(ext_irq[0]) && ext_irq[0] && $stable(ep_ff)) |=> ext_irq_event[0])
        else $error("rising edge missed");

    // falling edge on input 1 with negative polarity
    a_fall_evt1: assert property (@(posedge mclk) disable iff (!nrst)
        (ep_ff[1] && $past(ext_irq[1]) && !ext_irq[1]) |=> ext_irq_event[1])
        else $error("falling edge missed");

    // rising edge on input 2 with positive polarity
    a_rise_evt2: assert property (@(posedge mclk) disable iff (!nrst)
        (!ep_ff[2] && !$past(ext_irq[2]) && ext_irq[2]) |=> ext_irq_event[2])
        else $error("rising edge missed on input two");

    // an event pulse on input 0 needs a pin change
    a_evt_needs_edge: assert property (@(posedge mclk) disable iff (!nrst)
        ext_irq_event[0] |-> ($past(ext_irq[0]) != $past(ext_irq[0], 2)))
        else $error("event without pin change");

    // polarity bits take a low lane write
    a_ep_write: assert property (@(posedge mclk) disable iff (!nrst)
        (wr && hit_c2) |=> ep_ff == $past(pwdata[`CIP_ICTL2_EP_HI:0]))
        else $error("polarity write lost");

    // alternate vector select takes an upper lane write
    a_alt_vec: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_hi && hit_c2) |=> alt_vector_sel == $past(pwdata[`CIP_ICTL2_ALT]))
        else $error("alternate vector select not updated");

    // alternate vector select holds without a write
    a_alt_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !(wr_hi && hit_c2) |=> $stable(alt_vector_sel))
        else $error("alternate vector select changed without write");

    // nesting disable takes an upper lane write
    a_nest_write: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_hi && hit_c1) |=> nest_dis_ff == $past(pwdata[`CIP_ICTL1_NEST]))
        else $error("nesting disable write lost");

    // events stay set even against a clear in the same cycle
    a_set_wins: assert property (@(posedge mclk) disable iff (!nrst)
        (edge_hit != 3'h0) |=> ((irq_stat_ff & $past(edge_hit)) == $past(edge_hit)))
        else $error("event lost from status");

    // write one clears status bits
    a_w1c_clear: assert property (@(posedge mclk) disable iff (!nrst)
        (wr && hit_is && (edge_hit == 3'h0)) |=> ((irq_stat_ff & $past(pwdata[2:0])) == 3'h0))
        else $error("status bit not cleared");

    // status holds without events or clears
    a_stat_sticky: assert property (@(posedge mclk) disable iff (!nrst)
        (!(wr && hit_is) && (edge_hit == 3'h0)) |=> $stable(irq_stat_ff))
        else $error("status changed on its own");

    // a mask of zero keeps the interrupt low
    a_irq_masked: assert property (@(posedge mclk) disable iff (!nrst)
        ((irq_mask_ff == 3'h0) && ($past(irq_mask_ff) == 3'h0)) |-> !irq)
        else $error("interrupt high while fully masked");

    // one wait state, ready for exactly one cycle
    a_apb_ready: assert property (@(posedge mclk) disable iff (!nrst)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // ready only answers an access
    a_ready_cause: assert property (@(posedge mclk) disable iff (!nrst)
        pready |-> $past(psel && penable))
        else $error("ready without access");

    // error only with ready
    a_err_pairs: assert property (@(posedge mclk) disable iff (!nrst)
        pslverr |-> pready)
        else $error("error without ready");

    // unmapped offset answers with an error
    a_err_unmapped: assert property (@(posedge mclk) disable iff (!nrst)
        (psel && penable && !pready && !mapped) |=> pslverr)
        else $error("unmapped access without error");

    // read data holds between reads
    a_rd_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
        else $error("read data changed without read");
endmodule

// ### verilog/cip_params.svh
`ifndef CIP_PARAMS_SVH
`define CIP_PARAMS_SVH

// register byte offsets on the apb bus
`define CIP_OFS_STATUS 12'h000
`define CIP_OFS_CORE 12'h004
`define CIP_OFS_ICTL1 12'h008
`define CIP_OFS_ICTL2 12'h00c
`define CIP_OFS_IRQ_STAT 12'h010
`define CIP_OFS_IRQ_MASK 12'h014
`define CIP_OFS_CORE_IN 12'h018

// field positions
`define CIP_STATUS_PRIO_LO 5
`define CIP_STATUS_PRIO_HI 7
`define CIP_CORE_PRIO3 3
`define CIP_ICTL1_NEST 15
`define CIP_ICTL2_ALT 15
`define CIP_ICTL2_IDIS 14
`define CIP_ICTL2_EP_HI 2

// reset values and the level that blocks user requests
`define CIP_RST_PRIO 3'h0
`define CIP_RST_EP 3'h0
`define CIP_USER_OFF_LVL 4'h7

`endif

// ### verilog/cip_pkg.sv
package cip_pkg;
    typedef logic [3:0] cip_level_t;
    typedef enum logic [1:0] {CIP_STAT, CIP_CORE, CIP_CTL1, CIP_CTL2} cip_reg_e;
endpackage
